// ===== pmd_pkg.sv
// Constants shared by the peripheral disable controller and its helpers
package pmd_pkg;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam int IDX_W = 12;
	localparam logic [11:0] IDX_CTRL_0 = 12'h796;
	localparam logic [11:0] IDX_CTRL_1 = 12'h797;
	localparam logic [11:0] IDX_CTRL_2 = 12'h798;
	localparam logic [11:0] IDX_CTRL_3 = 12'h799;
	localparam logic [11:0] IDX_CTRL_4 = 12'h79A;
	localparam logic [11:0] IDX_CTRL_5 = 12'h79B;
	localparam logic [11:0] IDX_CTRL_6 = 12'h79C;
	localparam logic [11:0] IDX_CTRL_7 = 12'h79D;
	localparam logic [11:0] IDX_STATUS = 12'h79E;
	localparam int NUM_CTRL = 8;
	localparam int NUM_BITS = 64;

	// ************************************************************
	// Reset values and implemented-bit masks
	// ************************************************************
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CTRL_MASK [NUM_CTRL] = '{
		8'hC7, 8'h7F, 8'h80, 8'h67, 8'h6F, 8'h60, 8'h13, 8'h3F
	};

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BIT_PINCHG_OFF = 0;
	localparam int BIT_CLKREF_OFF = 1;
	localparam int BIT_NVM_OFF = 2;
	localparam int BIT_VREF_OFF = 6;
	localparam int BIT_SYSCLK_GATE = 7;
	localparam int BIT_ST_NVM_READY = 0;
	localparam int BIT_ST_SETTLING = 1;
	localparam int BIT_ST_SYSCLK_OFF = 2;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int NVM_WAKE_NS = 1000;
	localparam int NVM_WAKE_CYC = (NVM_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC = 2;
	localparam int CNT_W = 6;

	// ************************************************************
	// Bus encodings
	// ************************************************************
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic HRESP_OKAY = 1'b0;

endpackage : pmd_pkg

// ===== ahb_reg_port.sv
// AHB-Lite slave front end for the disable control registers
module ahb_reg_port
	import pmd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Register file side
	output logic rdReq,
	output logic [pmd_pkg::IDX_W-1:0] rdIdx,
	input wire logic [7:0] rdWord,
	output logic wrStb,
	output logic [pmd_pkg::IDX_W-1:0] wrIdx,
	output logic [7:0] wrData
);
	logic accept;
	logic wrPend_r;
	logic [IDX_W-1:0] wrIdx_r;
	logic [31:0] hrdata_r;

	// Address phase decode, word index from byte address
	assign accept = hsel & htrans[1] & hready;
	assign rdReq = accept & ~hwrite;
	assign rdIdx = haddr[IDX_W+1:2];

	// Data phase write strobe, low byte only
	assign wrStb = wrPend_r;
	assign wrIdx = wrIdx_r;
	assign wrData = hwdata[7:0];

	// Capture address phase; read data is ready for the data phase
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrIdx_r <= '0;
			hrdata_r <= 32'h0000_0000;
		end else begin
			wrPend_r <= accept & hwrite;
			wrIdx_r <= haddr[IDX_W+1:2];
			hrdata_r <= rdReq ? {24'h00_0000, rdWord} : 32'h0000_0000;
		end
	end

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hrdata = hrdata_r;
	assign hresp = HRESP_OKAY;

	// hsize unused: only whole-word transfers reach this slave
	logic unusedSize;
	assign unusedSize = ^hsize;

endmodule : ahb_reg_port

// ===== access_gate.sv
// Gate between the core and one peripheral register port
module access_gate #(
	parameter int DATA_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Peripheral state
	input wire logic blocked,
	// Core side
	input wire logic wrReq,
	input wire logic rdReq,
	output logic wrGrant,
	output logic rdValid,
	output logic [DATA_W-1:0] rdData,
	// Peripheral side
	input wire logic [DATA_W-1:0] rdRaw
);
	logic wrGrant_r;
	logic rdValid_r;
	logic [DATA_W-1:0] rdData_r;

	// Blocked: writes dropped, reads answered with zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrGrant_r <= 1'b0;
			rdValid_r <= 1'b0;
			rdData_r <= '0;
		end else begin
			wrGrant_r <= wrReq & ~blocked;
			rdValid_r <= rdReq;
			rdData_r <= (rdReq & ~blocked) ? rdRaw : '0;
		end
	end

	assign wrGrant = wrGrant_r;
	assign rdValid = rdValid_r;
	assign rdData = rdData_r;

endmodule : access_gate

// ===== peripheral_module_disable.sv
// Peripheral module disable controller with AHB-Lite register access
//
// Decided for this implementation: the AHB-Lite register port.

// Overview of operation
// - A set disable bit holds its peripheral in reset; clear leaves it running.
// - Disabled peripheral registers ignore writes and read as zero.
// - Outputs of a disabled peripheral are forced inactive.
// - Clearing the bit restarts the peripheral from power-on values.
// - Any system reset clears every disable bit.
// - Control 0 bit 7 stops system clock distribution to peripherals.
// - Only system-clocked peripherals lose their clock from that gate.
// - Control 0 bit 2 blocks memory access, control writes and indirect reads.
// - Control 0: bit 6 voltage reference, bit 1 clock output, bit 0 pin change.
// - Control 1 bits 0 to 6 disable timers 0 to 6.
// - Control 2 bit 7 disables the numeric oscillator.
// - Control 3: DAC, converter, two comparators, zero-cross detector.
// - Disabled peripheral has its clock and activity stopped.
// - Control 4: two pulse modulators and four capture/compare units.
// - Control 5: two waveform generators at bits 6 and 5.
// - Control 6: async serial bit 4, sync serial ports bits 1 and 0.
// - Control 7: measurement timer, four logic cells, signal modulator.
module peripheral_module_disable
	import pmd_pkg::*;
#(
	parameter logic [63:0] SYSCLK_USERS = 64'h3F13_606F_6780_7F47
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Peripheral control, one bit per control register bit position
	output logic [pmd_pkg::NUM_BITS-1:0] periphHoldReset,
	output logic [pmd_pkg::NUM_BITS-1:0] periphRestart,
	output logic [pmd_pkg::NUM_BITS-1:0] periphClkEn,
	input wire logic [pmd_pkg::NUM_BITS-1:0] periphOutRaw,
	output logic [pmd_pkg::NUM_BITS-1:0] periphOut,
	// Peripheral register access from the core
	input wire logic [5:0] sfrSel,
	input wire logic sfrWrReq,
	input wire logic sfrRdReq,
	input wire logic [7:0] sfrRdRaw,
	output logic sfrWrGrant,
	output logic sfrRdValid,
	output logic [7:0] sfrRdData,
	// Nonvolatile memory access from the core
	input wire logic nvmWrReq,
	input wire logic nvmRdReq,
	input wire logic [7:0] nvmRdRaw,
	output logic nvmWrGrant,
	output logic nvmRdValid,
	output logic [7:0] nvmRdData,
	output logic nvmBlock,
	output logic nvmReady
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0] ctrl_r [NUM_CTRL];
	logic [7:0] ctrlNxt [NUM_CTRL];
	logic [NUM_BITS-1:0] disVec;
	logic [NUM_BITS-1:0] disVecNxt;
	logic [NUM_BITS-1:0] validVec;
	logic [NUM_BITS-1:0] gateVec;
	logic [NUM_BITS-1:0] holdReset_r;
	logic [NUM_BITS-1:0] restart_r;
	logic [NUM_BITS-1:0] clkEn_r;
	logic [NUM_BITS-1:0] outQ_r;
	logic rdReq;
	logic [IDX_W-1:0] rdIdx;
	logic [7:0] rdWord;
	logic wrStb;
	logic [IDX_W-1:0] wrIdx;
	logic [7:0] wrData;
	logic [3:0] wrSlot;
	logic [3:0] rdSlot;
	logic sysGate;
	logic nvmOff;
	logic [CNT_W-1:0] nvmCnt_r;
	logic nvmReady_r;
	logic nvmBlock_r;
	logic [CNT_W-1:0] settleCnt_r;
	logic anyRestart;
	logic [7:0] statusWord;
	logic sfrBlocked;

	// ************************************************************
	// Decoding helpers
	// ************************************************************

	// Hit flag and slot of a control register index
	function automatic logic [3:0] ctrlSlot(input logic [IDX_W-1:0] idx);
		logic [IDX_W-1:0] off;
		off = idx - IDX_CTRL_0;
		if (idx >= IDX_CTRL_0 && idx <= IDX_CTRL_7) begin
			return {1'b1, off[2:0]};
		end
		return 4'h0;
	endfunction : ctrlSlot

	// ************************************************************
	// Bus front end
	// ************************************************************
	ahb_reg_port u_port (
		.clk_sys(clk_sys),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.rdReq(rdReq),
		.rdIdx(rdIdx),
		.rdWord(rdWord),
		.wrStb(wrStb),
		.wrIdx(wrIdx),
		.wrData(wrData)
	);

	// ************************************************************
	// Control registers
	// ************************************************************
	assign wrSlot = ctrlSlot(wrIdx);
	assign rdSlot = ctrlSlot(rdIdx);

	// Next values; unused positions masked off
	always_comb begin
		for (int i = 0; i < NUM_CTRL; i++) begin
			if (wrStb && wrSlot[3] && wrSlot[2:0] == 3'(i)) begin
				ctrlNxt[i] = wrData & CTRL_MASK[i];
			end else begin
				ctrlNxt[i] = ctrl_r[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < NUM_CTRL; i++) begin
			if (rst) begin
				ctrl_r[i] <= CTRL_RST;
			end else begin
				ctrl_r[i] <= ctrlNxt[i];
			end
		end
	end

	// Flat views of present and next disable bits
	// bit layout
	assign disVec = {ctrl_r[7], ctrl_r[6], ctrl_r[5], ctrl_r[4],
		ctrl_r[3], ctrl_r[2], ctrl_r[1], ctrl_r[0]};
	assign disVecNxt = {ctrlNxt[7], ctrlNxt[6], ctrlNxt[5], ctrlNxt[4],
		ctrlNxt[3], ctrlNxt[2], ctrlNxt[1], ctrlNxt[0]};
	assign validVec = {CTRL_MASK[7], CTRL_MASK[6], CTRL_MASK[5], CTRL_MASK[4],
		CTRL_MASK[3], CTRL_MASK[2], CTRL_MASK[1], CTRL_MASK[0]};

	// Read mux uses next values so a write then read sees new data
	assign statusWord = {5'h00, sysGate, (settleCnt_r != '0), nvmReady_r};
	assign rdWord = rdSlot[3] ? ctrlNxt[rdSlot[2:0]] :
		(rdIdx == IDX_STATUS) ? statusWord : 8'h00;

	// ************************************************************
	// Peripheral reset, clock and output control
	// ************************************************************
	// system clock gate bit
	assign sysGate = ctrl_r[0][BIT_SYSCLK_GATE];
	// only system-clocked peripherals gated
	// Gate follows the next value so it lands on the same edge as the disable bits
	assign gateVec = SYSCLK_USERS & validVec & {NUM_BITS{ctrlNxt[0][BIT_SYSCLK_GATE]}};
	assign anyRestart = |(disVec & ~disVecNxt);

	// Peripheral control flops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			holdReset_r <= '0;
			restart_r <= '0;
			clkEn_r <= '0;
			outQ_r <= '0;
		end else begin
			holdReset_r <= disVecNxt & validVec;
			restart_r <= disVec & ~disVecNxt;
			clkEn_r <= validVec & ~disVecNxt & ~gateVec;
			outQ_r <= periphOutRaw & validVec & ~disVec;
		end
	end

	assign periphHoldReset = holdReset_r;
	assign periphRestart = restart_r;
	assign periphClkEn = clkEn_r;
	assign periphOut = outQ_r;

	// ************************************************************
	// Settling window after re-enable, shown in status
	// ************************************************************
	// quiet window reported to software
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			settleCnt_r <= '0;
		end else if (anyRestart) begin
			settleCnt_r <= CNT_W'(SETTLE_CYC);
		end else if (settleCnt_r != '0) begin
			settleCnt_r <= settleCnt_r - CNT_W'(1);
		end
	end

	// ************************************************************
	// Peripheral register access gate
	// ************************************************************
	// disabled registers unimplemented
	assign sfrBlocked = disVec[sfrSel] | ~validVec[sfrSel];

	access_gate #(.DATA_W(8)) u_sfr_gate (
		.clk_sys(clk_sys),
		.rst(rst),
		.blocked(sfrBlocked),
		.wrReq(sfrWrReq),
		.rdReq(sfrRdReq),
		.wrGrant(sfrWrGrant),
		.rdValid(sfrRdValid),
		.rdData(sfrRdData),
		.rdRaw(sfrRdRaw)
	);

	// ************************************************************
	// Nonvolatile memory gate
	// ************************************************************
	// memory access blocked
	assign nvmOff = ctrl_r[0][BIT_NVM_OFF];

	access_gate #(.DATA_W(8)) u_nvm_gate (
		.clk_sys(clk_sys),
		.rst(rst),
		.blocked(nvmOff),
		.wrReq(nvmWrReq),
		.rdReq(nvmRdReq),
		.wrGrant(nvmWrGrant),
		.rdValid(nvmRdValid),
		.rdData(nvmRdData),
		.rdRaw(nvmRdRaw)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nvmCnt_r <= '0;
			nvmReady_r <= 1'b1;
			nvmBlock_r <= 1'b0;
		end else begin
			nvmBlock_r <= ctrlNxt[0][BIT_NVM_OFF];
			if (ctrlNxt[0][BIT_NVM_OFF]) begin
				nvmCnt_r <= CNT_W'(NVM_WAKE_CYC);
				nvmReady_r <= 1'b0;
			end else if (nvmCnt_r != '0) begin
				nvmCnt_r <= nvmCnt_r - CNT_W'(1);
				nvmReady_r <= (nvmCnt_r == CNT_W'(1));
			end
		end
	end

	assign nvmReady = nvmReady_r;
	assign nvmBlock = nvmBlock_r;

endmodule : peripheral_module_disable

// ===== pmd_assertions.sv
// Port checks for the peripheral disable controller
module pmd_checker
	import pmd_pkg::*;
#(
	parameter logic [63:0] SYSCLK_USERS = 64'h3F13_606F_6780_7F47
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Peripheral control
	input wire logic [pmd_pkg::NUM_BITS-1:0] periphHoldReset,
	input wire logic [pmd_pkg::NUM_BITS-1:0] periphRestart,
	input wire logic [pmd_pkg::NUM_BITS-1:0] periphClkEn,
	input wire logic [pmd_pkg::NUM_BITS-1:0] periphOut,
	// Register gates
	input wire logic [5:0] sfrSel,
	input wire logic sfrWrReq,
	input wire logic sfrRdReq,
	input wire logic sfrWrGrant,
	input wire logic sfrRdValid,
	input wire logic [7:0] sfrRdData,
	input wire logic nvmRdReq,
	input wire logic nvmRdValid,
	input wire logic [7:0] nvmRdData,
	input wire logic nvmBlock,
	input wire logic nvmReady
);
	localparam logic [63:0] IMPL_BITS = 64'h3F13_606F_6780_7FC7;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ************************************************************
	// Assertions
	// ************************************************************
	a_reset_clears: assert property (disable iff (1'b0)
		rst |=> periphHoldReset == '0) else $error("disable bits survive reset");
	a_restart_pulse: assert property (
		!$past(rst) |-> periphRestart == ($past(periphHoldReset) & ~periphHoldReset))
		else $error("restart pulse wrong");
	a_out_forced: assert property (
		(periphOut & periphHoldReset & $past(periphHoldReset)) == '0)
		else $error("disabled output active");
	a_clk_stopped: assert property ((periphClkEn & periphHoldReset) == '0)
		else $error("disabled peripheral clocked");
	a_clk_map: assert property (!$past(rst) |-> periphClkEn ==
		(IMPL_BITS & ~periphHoldReset & (periphHoldReset[7] ? ~SYSCLK_USERS : '1)))
		else $error("clock enable map wrong");
	a_sfr_refuse: assert property (
		sfrWrReq && periphHoldReset[sfrSel] |=> !sfrWrGrant) else $error("write granted");
	a_sfr_zero: assert property (sfrRdReq && periphHoldReset[sfrSel] |=>
		sfrRdValid && sfrRdData == 8'h00) else $error("disabled read not zero");
	a_sfr_grant: assert property (
		sfrWrReq && IMPL_BITS[sfrSel] && !periphHoldReset[sfrSel] |=> sfrWrGrant)
		else $error("enabled write refused");
	a_nvm_follow: assert property (nvmBlock == periphHoldReset[2])
		else $error("memory block mismatch");
	a_nvm_zero: assert property (nvmRdReq && nvmBlock |=>
		nvmRdValid && nvmRdData == 8'h00) else $error("blocked memory read not zero");
	a_nvm_wake: assert property ($fell(nvmBlock) && !$past(rst) |->
		!nvmReady [*8] ##[1:24] nvmReady) else $error("memory wake timing wrong");
	a_unused_zero: assert property ((periphHoldReset & ~IMPL_BITS) == '0)
		else $error("unused bit set");
	// Main scenarios
	c_refused: cover property (sfrWrReq && periphHoldReset[sfrSel]);
	c_wake: cover property ($fell(nvmBlock));
	c_restart: cover property (periphRestart != '0);
endmodule : pmd_checker

bind peripheral_module_disable pmd_checker #(.SYSCLK_USERS(SYSCLK_USERS)) pmd_checker_i (
	.clk_sys, .rst, .periphHoldReset, .periphRestart, .periphClkEn, .periphOut, .sfrSel,
	.sfrWrReq, .sfrRdReq, .sfrWrGrant, .sfrRdValid, .sfrRdData, .nvmRdReq, .nvmRdValid,
	.nvmRdData, .nvmBlock, .nvmReady);

// ===== tb.sv
// Self-checking testbench for the peripheral disable controller
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pmd_pkg::*;
	localparam logic [63:0] IMPL_BITS = 64'h3F13_606F_6780_7FC7;
	logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, sfrWrReq, sfrRdReq, sfrWrGrant;
	logic sfrRdValid, nvmWrReq, nvmRdReq, nvmWrGrant, nvmRdValid, nvmBlock, nvmReady;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [5:0] sfrSel;
	logic [7:0] sfrRdRaw, sfrRdData, nvmRdRaw, nvmRdData;
	logic [31:0] haddr, hwdata, hrdata, rdS, rd;
	logic [63:0] periphHoldReset, periphRestart, periphClkEn, periphOutRaw, periphOut;
	int errors, n_checks, i;

	peripheral_module_disable peripheral_module_disable_i (.clk_sys, .rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.periphHoldReset, .periphRestart, .periphClkEn, .periphOutRaw, .periphOut, .sfrSel,
		.sfrWrReq, .sfrRdReq, .sfrRdRaw, .sfrWrGrant, .sfrRdValid, .sfrRdData, .nvmWrReq,
		.nvmRdReq, .nvmRdRaw, .nvmWrGrant, .nvmRdValid, .nvmRdData, .nvmBlock, .nvmReady);

	// Clock and read data captured at the edge
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) rdS <= hrdata;

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check

	// Single AHB-Lite word transfer to a register index
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {18'h0, idx, 2'h0};
		hsize <= 3'h2;
		hwrite <= wr;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= HTRANS_IDLE;
		hwdata <= {24'h0, wd};
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		#1;
		rd = rdS;
	endtask : bus

	// One request on the peripheral or memory gate
	task automatic poke(input logic nvm, input logic wr, input logic [5:0] sel);
		@(posedge clk_sys);
		sfrSel <= sel;
		sfrWrReq <= wr & ~nvm;
		sfrRdReq <= ~wr & ~nvm;
		nvmWrReq <= wr & nvm;
		nvmRdReq <= ~wr & nvm;
		@(posedge clk_sys);
		{sfrWrReq, sfrRdReq, nvmWrReq, nvmRdReq} <= 4'h0;
		#1;
	endtask : poke

	task automatic tally_and_finish();
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// Watchdog against a hung wait
	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{hsel, hwrite, sfrWrReq, sfrRdReq, nvmWrReq, nvmRdReq} = 6'h00;
		{htrans, hsize, haddr, hwdata, sfrSel} = '0;
		{sfrRdRaw, nvmRdRaw, periphOutRaw} = {8'hA5, 8'h3C, 64'hFFFF_FFFF_FFFF_FFFF};
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (i = 0; i < NUM_CTRL; i++) begin
			bus(1'b0, IDX_CTRL_0 + 12'(i), 8'h00);
			check("ctrl reset", 64'h0, rd);
		end
		check("clock enable", IMPL_BITS, periphClkEn);
		for (i = 0; i < NUM_CTRL; i++) begin
			bus(1'b1, IDX_CTRL_0 + 12'(i), 8'hFF);
			bus(1'b0, IDX_CTRL_0 + 12'(i), 8'h00);
			check("ctrl readback", 64'(CTRL_MASK[i]), rd);
		end
		check("hold vector", IMPL_BITS, periphHoldReset);
		check("clock enable", 64'h0, periphClkEn);
		check("outputs", 64'h0, periphOut);
		bus(1'b0, IDX_STATUS, 8'h00);
		check("status", 64'h04, rd);
		bus(1'b1, 12'h79F, 8'hFF);
		bus(1'b0, 12'h79F, 8'h00);
		check("unmapped", 64'h0, rd);
		poke(1'b0, 1'b1, 6'd8);
		check("sfr grant", 64'h0, sfrWrGrant);
		poke(1'b0, 1'b0, 6'd8);
		check("sfr read", 64'h100, {sfrRdValid, sfrRdData});
		poke(1'b1, 1'b1, 6'd0);
		check("nvm grant", 64'h0, nvmWrGrant);
		poke(1'b1, 1'b0, 6'd0);
		check("nvm read", 64'h200, {nvmRdValid, nvmRdData, nvmReady});
		bus(1'b1, IDX_CTRL_1, 8'h00);
		check("restart", 64'h7F00, periphRestart);
		repeat (2) @(posedge clk_sys);
		poke(1'b0, 1'b1, 6'd8);
		check("sfr grant", 64'h1, sfrWrGrant);
		poke(1'b0, 1'b0, 6'd8);
		check("sfr read", 64'h1A5, {sfrRdValid, sfrRdData});
		check("outputs", 64'h7F00, periphOut);
		bus(1'b1, IDX_CTRL_0, 8'h80);
		check("gated clock", 64'h0, periphClkEn);
		for (i = 0; i < 40 && nvmReady !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		check("wake time", 64'h1, 64'(i >= NVM_WAKE_CYC - 1 && i <= NVM_WAKE_CYC + 1));
		bus(1'b1, IDX_CTRL_0, 8'h00);
		check("clock enable", 64'h7FC7, periphClkEn);
		poke(1'b1, 1'b0, 6'd0);
		check("nvm read", 64'h13C, {nvmRdValid, nvmRdData});
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, IDX_CTRL_3, 8'h00);
		check("ctrl after reset", 64'h0, rd);
		check("hold after reset", 64'h0, periphHoldReset);
		tally_and_finish();
	end
endmodule : tb
